// ### design/adc_core_offset_trim_regs.sv
// Operation
// - Each trim word: unsigned 12-bit value low, four reserved read/write bits reset zero.
// - Word at 0x08C trims first core while it samples second input.
// - Word at 0x08E trims second core while it samples first input.
// - Word at 0x090 trims second core while it samples second input.
// - Word at 0x092 trims third core sampling first input, same layout.
// - After reset value holds factory trim, readable and overwritable by software.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "offset_trim_consts.svh"

module adc_core_offset_trim_regs #(
   parameter logic [11:0] FACTORY_CORE0_SECOND = `FACTORY_TRIM_DEFAULT,
   parameter logic [11:0] FACTORY_CORE1_FIRST = `FACTORY_TRIM_DEFAULT,
   parameter logic [11:0] FACTORY_CORE1_SECOND = `FACTORY_TRIM_DEFAULT,
   parameter logic [11:0] FACTORY_CORE2_FIRST = `FACTORY_TRIM_DEFAULT
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Register port
   input wire offset_trim_pkg::reg_req_t reg_req,
   output logic [15:0] reg_rdata_r,
   // Calibration engine state
   input wire offset_trim_pkg::cal_state_t cal_state,
   // Second core input choice, high while it samples the second input
   input wire logic core1_on_second_input,
   // Offsets to the cores
   output offset_trim_pkg::trim_values_t trim_values,
   output logic [11:0] core1_applied_offset_r
);

   logic [15:0] word_core0_second;
   logic [15:0] word_core1_first;
   logic [15:0] word_core1_second;
   logic [15:0] word_core2_first;
   logic sel_core0_second;
   logic sel_core1_first;
   logic sel_core1_second;
   logic sel_core2_first;
   logic sel_status;
   logic trim_hit;
   logic unsafe_write;
   logic unsafe_read;
   logic write_in_cal_r;
   logic read_not_ready_r;
   logic clr_write_in_cal;
   logic clr_read_not_ready;
   logic [15:0] status_word;
   logic [15:0] reg_rdata_nxt;
   logic [11:0] core1_applied_offset_nxt;

   // Address decode, 16-bit word at each of five even byte addresses
   always_comb
   begin
      sel_core0_second = (reg_req.addr == `ADDR_CORE0_SECOND);
      sel_core1_first = (reg_req.addr == `ADDR_CORE1_FIRST);
      sel_core1_second = (reg_req.addr == `ADDR_CORE1_SECOND);
      sel_core2_first = (reg_req.addr == `ADDR_CORE2_FIRST);
      sel_status = (reg_req.addr == `ADDR_CAL_STATUS);
      trim_hit = sel_core0_second | sel_core1_first | sel_core1_second | sel_core2_first;
   end

   // Trim words, reset to factory values
   trim_word_reg #(
      .RESET_VAL(FACTORY_CORE0_SECOND)
   ) u_core0_second (
      .clk_sys(clk_sys),
      .reset(reset),
      .wr_en(reg_req.wr & sel_core0_second),
      .wr_data(reg_req.wdata),
      .word_r(word_core0_second)
   );

   trim_word_reg #(
      .RESET_VAL(FACTORY_CORE1_FIRST)
   ) u_core1_first (
      .clk_sys(clk_sys),
      .reset(reset),
      .wr_en(reg_req.wr & sel_core1_first),
      .wr_data(reg_req.wdata),
      .word_r(word_core1_first)
   );

   trim_word_reg #(
      .RESET_VAL(FACTORY_CORE1_SECOND)
   ) u_core1_second (
      .clk_sys(clk_sys),
      .reset(reset),
      .wr_en(reg_req.wr & sel_core1_second),
      .wr_data(reg_req.wdata),
      .word_r(word_core1_second)
   );

   trim_word_reg #(
      .RESET_VAL(FACTORY_CORE2_FIRST)
   ) u_core2_first (
      .clk_sys(clk_sys),
      .reset(reset),
      .wr_en(reg_req.wr & sel_core2_first),
      .wr_data(reg_req.wdata),
      .word_r(word_core2_first)
   );

   // Value fields straight to the cores
   assign trim_values.core0_second = word_core0_second[`TRIM_VAL_MSB:`TRIM_VAL_LSB];
   assign trim_values.core1_first = word_core1_first[`TRIM_VAL_MSB:`TRIM_VAL_LSB];
   assign trim_values.core1_second = word_core1_second[`TRIM_VAL_MSB:`TRIM_VAL_LSB];
   assign trim_values.core2_first = word_core2_first[`TRIM_VAL_MSB:`TRIM_VAL_LSB];

   // Accesses software should avoid in the current calibration state
   always_comb
   begin
      unsafe_write = cal_state.fg_running
                   | (cal_state.background_cal_enable
                      & cal_state.background_offset_cal_enable);
      unsafe_read = (cal_state.offset_cal_enable
                     & ~cal_state.background_offset_cal_enable
                     & ~cal_state.foreground_cal_done_flag)
                  | (cal_state.background_cal_enable
                     & cal_state.background_offset_cal_enable
                     & ~cal_state.cal_paused_flag);
      clr_write_in_cal = reg_req.wr & sel_status & reg_req.wdata[`STAT_WRITE_IN_CAL];
      clr_read_not_ready = reg_req.wr & sel_status & reg_req.wdata[`STAT_READ_NOT_READY];
   end

   // Sticky record of a trim write during calibration
   sticky_flag u_write_in_cal (
      .clk_sys(clk_sys),
      .reset(reset),
      .set_pulse(reg_req.wr & trim_hit & unsafe_write),
      .clr_pulse(clr_write_in_cal),
      .flag_r(write_in_cal_r)
   );

   // Sticky record of a trim read before results are settled
   sticky_flag u_read_not_ready (
      .clk_sys(clk_sys),
      .reset(reset),
      .set_pulse(reg_req.rd & trim_hit & unsafe_read),
      .clr_pulse(clr_read_not_ready),
      .flag_r(read_not_ready_r)
   );

   // Calibration status word
   always_comb
   begin
      status_word = 16'h0000;
      status_word[`STAT_FG_RUNNING] = cal_state.fg_running;
      status_word[`STAT_BG_ENABLE] = cal_state.background_cal_enable;
      status_word[`STAT_BG_OS_ENABLE] = cal_state.background_offset_cal_enable;
      status_word[`STAT_OS_ENABLE] = cal_state.offset_cal_enable;
      status_word[`STAT_FOREGROUND_CAL_DONE_FLAG] = cal_state.foreground_cal_done_flag;
      status_word[`STAT_CAL_PAUSED] = cal_state.cal_paused_flag;
      status_word[`STAT_WRITE_IN_CAL] = write_in_cal_r;
      status_word[`STAT_READ_NOT_READY] = read_not_ready_r;
   end

   // Read mux, data valid only in the cycle after the strobe
   always_comb
   begin
      reg_rdata_nxt = 16'h0000;
      if (reg_req.rd)
      begin
         if (sel_core0_second)
         begin
            reg_rdata_nxt = word_core0_second;
         end
         else if (sel_core1_first)
         begin
            reg_rdata_nxt = word_core1_first;
         end
         else if (sel_core1_second)
         begin
            reg_rdata_nxt = word_core1_second;
         end
         else if (sel_core2_first)
         begin
            reg_rdata_nxt = word_core2_first;
         end
         else if (sel_status)
         begin
            reg_rdata_nxt = status_word;
         end
      end
   end

   // Offset for the second core follows its input choice
   always_comb
   begin
      if (core1_on_second_input)
      begin
         core1_applied_offset_nxt = trim_values.core1_second;
      end
      else
      begin
         core1_applied_offset_nxt = trim_values.core1_first;
      end
   end

   // Output registers
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         reg_rdata_r <= 16'h0000;
         core1_applied_offset_r <= 12'h000;
      end
      else
      begin
         reg_rdata_r <= reg_rdata_nxt;
         core1_applied_offset_r <= core1_applied_offset_nxt;
      end
   end

   // Checks on the register bank
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   reserved_bits_kept_a : assert property (
      (reg_req.wr && trim_hit)
      |=> (reg_rdata_nxt == 16'h0000 || !reg_req.rd
           || !(reg_req.addr == $past(reg_req.addr))
           || reg_rdata_nxt[15:12] == $past(reg_req.wdata[15:12])))
   else $error("reserved nibble not kept as written");

   core0_second_write_a : assert property (
      (reg_req.wr && reg_req.addr == `ADDR_CORE0_SECOND)
      |=> trim_values.core0_second == $past(reg_req.wdata[11:0]))
   else $error("first core second input trim not written");

   core1_first_write_a : assert property (
      (reg_req.wr && reg_req.addr == `ADDR_CORE1_FIRST)
      |=> trim_values.core1_first == $past(reg_req.wdata[11:0]))
   else $error("second core first input trim not written");

   core1_second_write_a : assert property (
      (reg_req.wr && reg_req.addr == `ADDR_CORE1_SECOND)
      |=> trim_values.core1_second == $past(reg_req.wdata[11:0]))
   else $error("second core second input trim not written");

   core2_first_write_a : assert property (
      (reg_req.wr && reg_req.addr == `ADDR_CORE2_FIRST)
      |=> trim_values.core2_first == $past(reg_req.wdata[11:0]))
   else $error("third core first input trim not written");

   trim_hold_a : assert property (
      !(reg_req.wr && trim_hit) |=> $stable(trim_values))
   else $error("trim changed without a write");

   write_read_back_a : assert property (
      (reg_req.wr && reg_req.addr == `ADDR_CORE1_SECOND)
      ##1 (reg_req.rd && reg_req.addr == `ADDR_CORE1_SECOND)
      |=> reg_rdata_r == $past(reg_req.wdata, 2))
   else $error("trim word read back differs from write");

   unmapped_read_zero_a : assert property (
      (reg_req.rd && !trim_hit && !sel_status) |=> reg_rdata_r == 16'h0000)
   else $error("unmapped read not zero");

   read_data_one_cycle_a : assert property (
      !reg_req.rd |=> reg_rdata_r == 16'h0000)
   else $error("read data outside its cycle");

   core1_apply_follow_a : assert property (
      core1_on_second_input ##1 core1_on_second_input
      |-> core1_applied_offset_r == $past(trim_values.core1_second))
   else $error("second core offset not taken from second input trim");

   core1_apply_first_a : assert property (
      !core1_on_second_input ##1 !core1_on_second_input
      |-> core1_applied_offset_r == $past(trim_values.core1_first))
   else $error("second core offset not taken from first input trim");

   reserved_nibble_store_a : assert property (
      (reg_req.wr && sel_core1_second)
      |=> word_core1_second[`TRIM_RSV_MSB:`TRIM_RSV_LSB]
          == $past(reg_req.wdata[`TRIM_RSV_MSB:`TRIM_RSV_LSB]))
   else $error("reserved nibble of second core trim not stored");

   write_record_set_a : assert property (
      (reg_req.wr && trim_hit && unsafe_write) |=> write_in_cal_r)
   else $error("trim write during calibration not recorded");

   read_record_set_a : assert property (
      (reg_req.rd && trim_hit && unsafe_read) |=> read_not_ready_r)
   else $error("early trim read not recorded");

   write_record_clear_a : assert property (
      clr_write_in_cal |=> !write_in_cal_r)
   else $error("write record not cleared");

endmodule : adc_core_offset_trim_regs

`default_nettype wire

// ### design/sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none

module sticky_flag (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Events
   input wire logic set_pulse,
   input wire logic clr_pulse,
   // Flag
   output logic flag_r
);

   logic flag_nxt;

   // Set wins over a clear in the same cycle
   always_comb
   begin
      flag_nxt = set_pulse | (flag_r & ~clr_pulse);
   end

   // Flag storage
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         flag_r <= 1'b0;
      end
      else
      begin
         flag_r <= flag_nxt;
      end
   end

endmodule : sticky_flag

`default_nettype wire

// ### design/trim_word_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "offset_trim_consts.svh"

module trim_word_reg #(
   parameter logic [11:0] RESET_VAL = `FACTORY_TRIM_DEFAULT
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Write side
   input wire logic wr_en,
   input wire logic [15:0] wr_data,
   // Stored word
   output logic [15:0] word_r
);

   logic [15:0] word_nxt;

   // Whole word is writable, reserved nibble included
   always_comb
   begin
      word_nxt = word_r;
      if (wr_en)
      begin
         word_nxt = wr_data;
      end
   end

   // Reserved nibble resets to zero, value to the factory trim
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         word_r <= {`TRIM_RSV_RESET, RESET_VAL};
      end
      else
      begin
         word_r <= word_nxt;
      end
   end

endmodule : trim_word_reg

`default_nettype wire

// ### shared/offset_trim_consts.svh
`ifndef OFFSET_TRIM_CONSTS_SVH
`define OFFSET_TRIM_CONSTS_SVH

// Register port widths
`define TRIM_ADDR_W 8
`define TRIM_DATA_W 16
`define TRIM_VAL_W 12

// Trim word field layout
`define TRIM_VAL_MSB 11
`define TRIM_VAL_LSB 0
`define TRIM_RSV_MSB 15
`define TRIM_RSV_LSB 12
`define TRIM_RSV_RESET 4'h0

// Byte addresses of the trim words
`define ADDR_CORE0_SECOND 8'h8C
`define ADDR_CORE1_FIRST 8'h8E
`define ADDR_CORE1_SECOND 8'h90
`define ADDR_CORE2_FIRST 8'h92

// Calibration status word and its fields
`define ADDR_CAL_STATUS 8'hA0
`define STAT_FG_RUNNING 0
`define STAT_BG_ENABLE 1
`define STAT_BG_OS_ENABLE 2
`define STAT_OS_ENABLE 3
`define STAT_FOREGROUND_CAL_DONE_FLAG 4
`define STAT_CAL_PAUSED 5
`define STAT_WRITE_IN_CAL 8
`define STAT_READ_NOT_READY 9

// Default factory trim
`define FACTORY_TRIM_DEFAULT 12'h000

`endif

// ### shared/offset_trim_pkg.sv
`default_nettype none

package offset_trim_pkg;

   // Offset values as applied to the four core and input pairs
   typedef struct packed {
      logic [11:0] core0_second;
      logic [11:0] core1_first;
      logic [11:0] core1_second;
      logic [11:0] core2_first;
   } trim_values_t;

   // Calibration state seen from the calibration engine
   typedef struct packed {
      logic fg_running;
      logic background_cal_enable;
      logic background_offset_cal_enable;
      logic offset_cal_enable;
      logic foreground_cal_done_flag;
      logic cal_paused_flag;
   } cal_state_t;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage : offset_trim_pkg

`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "offset_trim_consts.svh"

module testbench;
   // Factory trims chosen non-zero so reset values are visible
   localparam logic [11:0] FAC0 = 12'h5A3;
   localparam logic [11:0] FAC1 = 12'h0C7;
   localparam logic [11:0] FAC2 = 12'hE19;
   localparam logic [11:0] FAC3 = 12'h7F0;

   logic clk_sys;
   logic reset;
   offset_trim_pkg::reg_req_t reg_req;
   logic [15:0] reg_rdata_r;
   offset_trim_pkg::cal_state_t cal_state;
   logic core1_on_second_input;
   offset_trim_pkg::trim_values_t trim_values;
   logic [11:0] core1_applied_offset_r;
   int mismatches;
   int check_count;
   logic [7:0] addr_tab [4];
   logic [11:0] fac_tab [4];
   logic [15:0] wr_tab [4];

   adc_core_offset_trim_regs #(
      .FACTORY_CORE0_SECOND(FAC0),
      .FACTORY_CORE1_FIRST(FAC1),
      .FACTORY_CORE1_SECOND(FAC2),
      .FACTORY_CORE2_FIRST(FAC3)
   ) dut (
      .clk_sys(clk_sys),
      .reset(reset),
      .reg_req(reg_req),
      .reg_rdata_r(reg_rdata_r),
      .cal_state(cal_state),
      .core1_on_second_input(core1_on_second_input),
      .trim_values(trim_values),
      .core1_applied_offset_r(core1_applied_offset_r)
   );

   // 100 MHz system clock
   always #5 clk_sys = ~clk_sys;

   // One comparison, counted and reported
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Single-cycle write strobe
   task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
      #1;
   endtask : wr_word

   // Single-cycle read strobe, data taken the cycle after
   task automatic rd_word(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      @(posedge clk_sys);
      reg_req.rd <= 1'b0;
      #1;
      d = reg_rdata_r;
   endtask : rd_word

   // Value field as driven to the cores
   function automatic logic [11:0] field(input int i);
      case (i)
         0: field = trim_values.core0_second;
         1: field = trim_values.core1_first;
         2: field = trim_values.core1_second;
         default: field = trim_values.core2_first;
      endcase
   endfunction : field

   // Factory values after reset, reserved nibble zero
   task automatic t_reset();
      logic [15:0] d;
      for (int i = 0; i < 4; i++)
      begin
         rd_word(addr_tab[i], d);
         chk("reset word", {4'h0, fac_tab[i]}, d);
         chk("reset field", {4'h0, fac_tab[i]}, {4'h0, field(i)});
      end
   endtask : t_reset

   // Overwrite of each word, one idle cycle between writes, reserved bits stored
   task automatic t_rw();
      logic [15:0] d;
      for (int i = 0; i < 4; i++)
      begin
         wr_word(addr_tab[i], wr_tab[i]);
         chk("field", {4'h0, wr_tab[i][11:0]}, {4'h0, field(i)});
      end
      for (int i = 0; i < 4; i++)
      begin
         rd_word(addr_tab[i], d);
         chk("readback", wr_tab[i], d);
      end
   endtask : t_rw

   // Odd byte address is not a second register
   task automatic t_unmapped();
      logic [15:0] d;
      wr_word(8'h8D, 16'hFFFF);
      rd_word(8'h8D, d);
      chk("odd addr", 16'h0000, d);
      rd_word(`ADDR_CORE0_SECOND, d);
      chk("neighbour", wr_tab[0], d);
      @(posedge clk_sys);
      #1;
      chk("rdata idle", 16'h0000, reg_rdata_r);
   endtask : t_unmapped

   // Second core picks its trim by input
   task automatic t_apply();
      @(posedge clk_sys);
      core1_on_second_input <= 1'b1;
      @(posedge clk_sys);
      #1;
      chk("second input", {4'h0, wr_tab[2][11:0]}, {4'h0, core1_applied_offset_r});
      @(posedge clk_sys);
      core1_on_second_input <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("first input", {4'h0, wr_tab[1][11:0]}, {4'h0, core1_applied_offset_r});
   endtask : t_apply

   // Write then read with no gap, reserved nibble kept zero
   task automatic t_b2b();
      @(posedge clk_sys);
      reg_req.addr <= `ADDR_CORE1_SECOND;
      reg_req.wdata <= 16'h0ABC;
      reg_req.wr <= 1'b1;
      @(posedge clk_sys);
      reg_req.wr <= 1'b0;
      reg_req.rd <= 1'b1;
      @(posedge clk_sys);
      reg_req.rd <= 1'b0;
      #1;
      chk("b2b readback", 16'h0ABC, reg_rdata_r);
      chk("b2b field", 16'h0ABC, {4'h0, trim_values.core1_second});
      @(posedge clk_sys);
      #1;
      chk("b2b rdata idle", 16'h0000, reg_rdata_r);
   endtask : t_b2b

   // Forbidden accesses are recorded in the status word
   task automatic t_guard();
      logic [5:0] st_tab [7];
      logic op_tab [7];
      logic [1:0] fl_tab [7];
      logic [15:0] d;
      logic [5:0] c;
      st_tab = '{6'h20, 6'h18, 6'h04, 6'h06, 6'h18, 6'h19, 6'h10};
      op_tab = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      fl_tab = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h2, 2'h0, 2'h0};
      for (int i = 0; i < 7; i++)
      begin
         @(posedge clk_sys);
         cal_state <= st_tab[i];
         if (op_tab[i])
            wr_word(`ADDR_CORE0_SECOND, wr_tab[0]);
         else
            rd_word(`ADDR_CORE0_SECOND, d);
         rd_word(`ADDR_CAL_STATUS, d);
         c = st_tab[i];
         chk("flags", {14'h0, fl_tab[i]}, {14'h0, d[9:8]});
         chk("state", {10'h0, c[0], c[1], c[2], c[3], c[4], c[5]}, {10'h0, d[5:0]});
         @(posedge clk_sys);
         cal_state <= '0;
         wr_word(`ADDR_CAL_STATUS, 16'h0300);
         rd_word(`ADDR_CAL_STATUS, d);
         chk("cleared", 16'h0000, d);
      end
   endtask : t_guard

   // Summary and verdict
   task automatic conclude();
      $display("Checks made %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // Main sequence
   initial
   begin
      clk_sys = 1'b0;
      reset = 1'b1;
      reg_req = '0;
      cal_state = '0;
      core1_on_second_input = 1'b0;
      mismatches = 0;
      check_count = 0;
      addr_tab = '{`ADDR_CORE0_SECOND, `ADDR_CORE1_FIRST, `ADDR_CORE1_SECOND, `ADDR_CORE2_FIRST};
      fac_tab = '{FAC0, FAC1, FAC2, FAC3};
      wr_tab = '{16'hA3C1, 16'h5ED2, 16'hF0E3, 16'h1FF4};
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset();
      t_rw();
      t_unmapped();
      t_apply();
      t_b2b();
      t_guard();
      conclude();
   end

   // Watchdog against a hang
   initial
   begin
      #200000;
      mismatches++;
      conclude();
   end
endmodule : testbench

`default_nettype wire
